// ---- src/ifsb_top.sv ----
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "ifsb_defines.svh"
// Operation
// - flag reads 1 after request or after software writes 1, else 0
// - all implemented flag bits read/write, reset to 0
// - reg0 bits 15..8: change notify to serial1
// - reg0 bits 7..0: timer three to external0
// - reg1 bits 15..8: capture six to serial2
// - reg1 bits 7..0: external two to external1
// - reg2 bits 15..13 always read 0
// - reg2 bits 12..8: fault b to encoder
// - reg2 bits 7..2: pulse to compare seven
// - reg2 bits 1,0: compare six, compare five
module ifsb_top (
	input  wire logic                 clk_sys,
	input  wire logic                 rstn,
	input  wire logic                 ce,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [31:0]          paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire ifsb_pkg::ifsb_flags0_s req_0,
	input  wire ifsb_pkg::ifsb_flags1_s req_1,
	input  wire ifsb_pkg::ifsb_flags2_s req_2,
	output ifsb_pkg::ifsb_flags0_s    flags_0,
	output ifsb_pkg::ifsb_flags1_s    flags_1,
	output ifsb_pkg::ifsb_flags2_s    flags_2,
	output logic                      irq
);
	import ifsb_pkg::*;

	localparam logic [15:0] IMPL_TAB [3] = '{
		`IFSB_IMPL0, `IFSB_IMPL1, `IFSB_IMPL2
	};
	localparam logic [4:0] OFF_TAB [3] = '{
		`IFSB_OFF_FLAG0, `IFSB_OFF_FLAG1, `IFSB_OFF_FLAG2
	};

	ifsb_apb_e                st;
	ifsb_apb_e                next_st;
	logic      [31:0]         rdata;
	logic      [31:0]         next_rdata;
	logic                     err;
	logic                     next_err;
	logic [`IFSB_EVW-1:0]     ev;
	logic [`IFSB_EVW-1:0]     next_ev;
	logic [`IFSB_EVW-1:0]     mask;
	logic [`IFSB_EVW-1:0]     next_mask;
	logic                     setup;
	logic                     acc_done;
	logic                     wr_done;
	logic                     hi_zero;
	logic      [4:0]          idx;
	ifsb_word_t               req_v   [3];
	ifsb_word_t               hreq_v  [3];
	ifsb_word_t               flag_v  [3];
	logic                     wr_v    [3];
	logic      [15:0]         wmask;

	ifsb_flag_if fi [3] ();

	// source-to-bit order is the struct field order
	assign req_v[0] = ifsb_word_t'(req_0);
	assign req_v[1] = ifsb_word_t'(req_1);
	assign req_v[2] = ifsb_word_t'(req_2);

	assign wmask   = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	assign idx     = paddr[`IFSB_AW-1:0];
	assign hi_zero = (paddr[31:`IFSB_AW] == 27'h000_0000);

	for (genvar k = 0; k < 3; k++) begin : g_bank
		assign fi[k].req   = req_v[k];
		assign fi[k].wr    = wr_v[k];
		assign fi[k].wdata = pwdata[15:0];
		assign fi[k].wmask = wmask;
		assign flag_v[k]   = fi[k].flags;
		assign hreq_v[k]   = req_v[k] & IMPL_TAB[k];
		assign wr_v[k]     = wr_done && (idx == OFF_TAB[k]);

		ifsb_flag_reg #(
			.IMPL (IMPL_TAB[k])
		) u_flag (
			.clk_sys (clk_sys),
			.rstn    (rstn),
			.ce      (ce),
			.fl      (fi[k])
		);
	end

	assign flags_0 = ifsb_flags0_s'(flag_v[0]);
	assign flags_1 = ifsb_flags1_s'(flag_v[1]);
	assign flags_2 = ifsb_flags2_s'(flag_v[2]);

	// apb slave: read data and error are latched at the first edge of a
	// transfer that has clock enable high, answered one cycle later;
	// clock enable low in setup or access only stretches the wait
	assign setup    = psel && ce && (st == APB_IDLE);
	assign pready   = psel && penable && ce && (st == APB_LOADED);
	assign pslverr  = pready && err;
	assign acc_done = pready;
	assign wr_done  = acc_done && pwrite && !err;

	always_comb begin
		next_st    = st;
		next_rdata = rdata;
		next_err   = err;
		// one snapshot per transfer: a request that lands during the
		// access shows on the next read
		if (setup) begin
			next_st    = APB_LOADED;
			next_err   = 1'b0;
			next_rdata = 32'h0000_0000;
			unique case (idx)
				`IFSB_OFF_FLAG0: next_rdata = {`IFSB_PAD, flag_v[0]};
				`IFSB_OFF_FLAG1: next_rdata = {`IFSB_PAD, flag_v[1]};
				`IFSB_OFF_FLAG2: next_rdata = {`IFSB_PAD, flag_v[2]};
				`IFSB_OFF_EV_STAT: next_rdata = {`IFSB_PAD_EV, ev};
				`IFSB_OFF_EV_MASK: next_rdata = {`IFSB_PAD_EV, mask};
				default: next_err = 1'b1;
			endcase
			if (!hi_zero) begin
				next_err = 1'b1;
			end
			if (next_err) begin
				next_rdata = 32'h0000_0000;
			end
		end else if (acc_done) begin
			next_st = APB_IDLE;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st    <= APB_IDLE;
			rdata <= 32'h0000_0000;
			err   <= 1'b0;
		end else if (ce) begin
			st    <= next_st;
			rdata <= next_rdata;
			err   <= next_err;
		end
	end

	assign prdata = rdata;

	// event status: write one to clear, a new event in the same cycle
	// stays set
	always_comb begin
		next_ev   = ev;
		next_mask = mask;
		if (wr_done && pstrb[0]) begin
			if (idx == `IFSB_OFF_EV_STAT) begin
				next_ev = ev & ~pwdata[`IFSB_EVW-1:0];
			end
			if (idx == `IFSB_OFF_EV_MASK) begin
				next_mask = pwdata[`IFSB_EVW-1:0];
			end
		end
		if (fi[0].new_req) begin
			next_ev[`IFSB_EV_REQ0] = 1'b1;
		end
		if (fi[1].new_req) begin
			next_ev[`IFSB_EV_REQ1] = 1'b1;
		end
		if (fi[2].new_req) begin
			next_ev[`IFSB_EV_REQ2] = 1'b1;
		end
		if (acc_done && err) begin
			next_ev[`IFSB_EV_BUSERR] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ev   <= `IFSB_RST_EV;
			mask <= `IFSB_RST_EV;
		end else if (ce) begin
			ev   <= next_ev;
			mask <= next_mask;
		end
	end

	// level output: stays high until software clears or masks every
	// pending event
	assign irq = |(ev & mask);

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	// bus phases seen by the read and write checks
	sequence s_access;
		psel && penable && ce;
	endsequence

	sequence s_setup_rd(logic [4:0] off);
		psel && !penable && !pwrite && ce && hi_zero && idx == off;
	endsequence

	sequence s_setup_wr(logic [4:0] off);
		psel && !penable && pwrite && ce && hi_zero && idx == off;
	endsequence

	// per bank: set, hold, write, set-wins and read-back of each word
	ifsb_word_t past_hreq  [3];
	ifsb_word_t wr_keep    [3];
	ifsb_word_t wr_new     [3];

	for (genvar k = 0; k < 3; k++) begin : g_chk
		assign past_hreq[k] = hreq_v[k];
		assign wr_keep[k]   = flag_v[k] & ~wmask;
		assign wr_new[k]    = pwdata[15:0] & wmask & IMPL_TAB[k];

		flag_set_a: assert property (
			ce && (hreq_v[k] != `IFSB_RST_FLAG)
			|=> (flag_v[k] & $past(past_hreq[k]))
				== $past(past_hreq[k])
		) else $error("requested flag not set");

		sticky_a: assert property (
			ce && !wr_v[k]
			|=> (flag_v[k] & $past(flag_v[k])) == $past(flag_v[k])
		) else $error("flag dropped without write");

		sw_write_a: assert property (
			ce && wr_v[k]
			|=> flag_v[k] == ($past(wr_keep[k]) | $past(wr_new[k])
				| $past(past_hreq[k]))
		) else $error("flag write result wrong");

		impl_only_a: assert property (
			(flag_v[k] & ~IMPL_TAB[k]) == `IFSB_RST_FLAG
		) else $error("unimplemented flag bit set");

		// a clear that meets a request in the same cycle loses
		set_wins_a: assert property (
			ce && wr_v[k]
				&& (hreq_v[k] & wmask & ~pwdata[15:0]) != `IFSB_RST_FLAG
			|=> (flag_v[k] & $past(past_hreq[k])) == $past(past_hreq[k])
		) else $error("clear beat a hardware set");

		req_event_a: assert property (
			ce && fi[k].new_req |=> ev[k]
		) else $error("request did not set its event bit");

		read_bank_a: assert property (
			s_setup_rd(OFF_TAB[k]) ##1 s_access
			|-> prdata == {`IFSB_PAD, $past(flag_v[k])}
		) else $error("flag register read data wrong");

		freeze_bank_a: assert property (
			!ce |=> $stable(flag_v[k])
		) else $error("flag word moved with clock enable low");
	end

	unimpl_read_a: assert property (
		setup && idx == `IFSB_OFF_FLAG2
		|=> prdata[15:13] == 3'b000
	) else $error("unimplemented bits read nonzero");

	sequence s_setup_rd0;
		psel && !penable && !pwrite && ce && hi_zero
			&& idx == `IFSB_OFF_FLAG0;
	endsequence

	read_back_a: assert property (
		s_setup_rd0 ##1 s_access
		|-> pready && !pslverr
			&& prdata == {`IFSB_PAD, $past(flag_v[0])}
	) else $error("flag read data wrong");

	ready_one_a: assert property (
		psel && !penable && ce ##1 s_access |-> pready
	) else $error("access not answered in first cycle");

	unmapped_a: assert property (
		psel && !penable && ce && !hi_zero ##1 s_access
		|-> pslverr && prdata == 32'h0000_0000
	) else $error("unmapped access not refused");

	irq_path_a: assert property (
		ce && fi[0].new_req && mask[`IFSB_EV_REQ0] && !wr_done
		|=> ev[`IFSB_EV_REQ0] && irq
	) else $error("request event did not raise irq");

	freeze_a: assert property (
		!ce |=> $stable(flag_v[0]) && $stable(ev) && $stable(prdata)
	) else $error("state moved with clock enable low");

	reset_zero_a: assert property (
		$past(!rstn) |-> flag_v[0] == `IFSB_RST_FLAG
			&& flag_v[2] == `IFSB_RST_FLAG && !irq
	) else $error("flags not clear after reset");

	// event status, mask and refused accesses
	ev_sticky_a: assert property (
		ce && !(wr_done && idx == `IFSB_OFF_EV_STAT)
		|=> (ev & $past(ev)) == $past(ev)
	) else $error("event bit dropped without clear");

	ev_clear_a: assert property (
		wr_done && pstrb[0] && idx == `IFSB_OFF_EV_STAT
			&& pwdata[`IFSB_EV_REQ0] && !fi[0].new_req
		|=> !ev[`IFSB_EV_REQ0]
	) else $error("event bit not cleared by a one");

	mask_write_a: assert property (
		wr_done && pstrb[0] && idx == `IFSB_OFF_EV_MASK
		|=> mask == $past(pwdata[`IFSB_EVW-1:0])
	) else $error("mask write lost");

	err_event_a: assert property (
		acc_done && err |=> ev[`IFSB_EV_BUSERR]
	) else $error("refused access left no event");

	refused_write_a: assert property (
		acc_done && err && pwrite && hreq_v[0] == `IFSB_RST_FLAG
			&& hreq_v[1] == `IFSB_RST_FLAG && hreq_v[2] == `IFSB_RST_FLAG
		|=> $stable(flag_v[0]) && $stable(flag_v[1])
			&& $stable(flag_v[2]) && $stable(mask)
	) else $error("refused write changed state");

	stat_read_a: assert property (
		s_setup_rd(`IFSB_OFF_EV_STAT) ##1 s_access
		|-> prdata == {`IFSB_PAD_EV, $past(ev)}
	) else $error("event status read wrong");

	mask_read_a: assert property (
		s_setup_rd(`IFSB_OFF_EV_MASK) ##1 s_access
		|-> prdata == {`IFSB_PAD_EV, $past(mask)}
	) else $error("event mask read wrong");

	write_ok_a: assert property (
		s_setup_wr(`IFSB_OFF_FLAG0) ##1 s_access |-> pready && !pslverr
	) else $error("mapped flag write refused");

endmodule

// ---- common/ifsb_defines.svh ----
`ifndef IFSB_DEFINES_SVH
`define IFSB_DEFINES_SVH

`define IFSB_OFF_FLAG0   5'h00
`define IFSB_OFF_FLAG1   5'h04
`define IFSB_OFF_FLAG2   5'h08
`define IFSB_OFF_EV_STAT 5'h0c
`define IFSB_OFF_EV_MASK 5'h10
`define IFSB_AW          5
`define IFSB_IMPL0       16'hffff
`define IFSB_IMPL1       16'hffff
`define IFSB_IMPL2       16'h1fff
`define IFSB_RST_FLAG    16'h0000
`define IFSB_EVW         4
`define IFSB_RST_EV      4'h0
`define IFSB_EV_REQ0     0
`define IFSB_EV_REQ1     1
`define IFSB_EV_REQ2     2
`define IFSB_EV_BUSERR   3
`define IFSB_FW          16
`define IFSB_PAD         16'h0000
`define IFSB_PAD_EV      28'h000_0000

`endif

// ---- common/ifsb_pkg.sv ----
package ifsb_pkg;

	typedef logic [15:0] ifsb_word_t;

	typedef enum logic [1:0] {
		APB_IDLE   = 2'b01,
		APB_LOADED = 2'b10
	} ifsb_apb_e;

	typedef struct packed {
		logic change_notify_flag;
		logic bus_collision_flag;
		logic two_wire_done_flag;
		logic nonvolatile_write_done_flag;
		logic conversion_done_flag;
		logic serial1_transmit_flag;
		logic serial1_receive_flag;
		logic synchronous_serial1_flag;
		logic timer_three_flag;
		logic timer_two_flag;
		logic compare_two_flag;
		logic capture_two_flag;
		logic timer_one_flag;
		logic compare_one_flag;
		logic capture_one_flag;
		logic external_zero_flag;
	} ifsb_flags0_s;

	typedef struct packed {
		logic capture_six_flag;
		logic capture_five_flag;
		logic capture_four_flag;
		logic capture_three_flag;
		logic can_one_flag;
		logic synchronous_serial2_flag;
		logic serial2_transmit_flag;
		logic serial2_receive_flag;
		logic external_two_flag;
		logic timer_five_flag;
		logic timer_four_flag;
		logic compare_four_flag;
		logic compare_three_flag;
		logic capture_eight_flag;
		logic capture_seven_flag;
		logic external_one_flag;
	} ifsb_flags1_s;

	typedef struct packed {
		logic [2:0] unused_bits;
		logic       fault_b_flag;
		logic       fault_a_flag;
		logic       low_voltage_flag;
		logic       converter_interface_flag;
		logic       quadrature_encoder_flag;
		logic       motor_pulse_flag;
		logic       can_two_flag;
		logic       external_four_flag;
		logic       external_three_flag;
		logic       compare_eight_flag;
		logic       compare_seven_flag;
		logic       compare_six_flag;
		logic       compare_five_flag;
	} ifsb_flags2_s;

endpackage

// ---- common/ifsb_flag_if.sv ----
`timescale 1ns/1ps
interface ifsb_flag_if;
	logic [15:0] req;
	logic        wr;
	logic [15:0] wdata;
	logic [15:0] wmask;
	logic [15:0] flags;
	logic        new_req;

	modport bank (input req, wr, wdata, wmask, output flags, new_req);
	modport ctrl (output req, wr, wdata, wmask, input flags, new_req);
endinterface

// ---- src/ifsb_flag_reg.sv ----
`timescale 1ns/1ps
`include "ifsb_defines.svh"
module ifsb_flag_reg #(
	parameter logic [15:0] IMPL = `IFSB_IMPL0
) (
	input  wire logic  clk_sys,
	input  wire logic  rstn,
	input  wire logic  ce,
	ifsb_flag_if.bank  fl
);
	import ifsb_pkg::*;

	ifsb_word_t flag;
	ifsb_word_t next_flag;

	for (genvar b = 0; b < `IFSB_FW; b++) begin : g_bit
		if (IMPL[b]) begin : g_impl
			always_comb begin
				next_flag[b] = flag[b];
				if (fl.wr && fl.wmask[b]) begin
					next_flag[b] = fl.wdata[b];
				end
				if (fl.req[b]) begin
					next_flag[b] = 1'b1;
				end
			end
		end else begin : g_unimpl
			assign next_flag[b] = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			flag <= `IFSB_RST_FLAG;
		end else if (ce) begin
			flag <= next_flag;
		end
	end

	assign fl.flags   = flag;
	assign fl.new_req = |(fl.req & IMPL);
endmodule

// ---- tb/ifsb_src_model.sv ----
`timescale 1ns/1ps
module ifsb_src_model (
	input  wire logic [47:0]       raise,
	output ifsb_pkg::ifsb_flags0_s req_0,
	output ifsb_pkg::ifsb_flags1_s req_1,
	output ifsb_pkg::ifsb_flags2_s req_2
);
	import ifsb_pkg::*;
	// same-clock strobes, low whenever no source is raising
	assign {req_2, req_1, req_0} = raise;
endmodule

// ---- tb/ifsb_top_test.sv ----
`timescale 1ns/1ps
module ifsb_top_test;
	import ifsb_pkg::*;
	logic         clk_sys = 1'b0;
	logic         rstn    = 1'b0;
	logic         psel    = 1'b0;
	logic         penable = 1'b0;
	logic         pwrite  = 1'b0;
	logic [31:0]  paddr   = 32'h0000_0000;
	logic [31:0]  pwdata  = 32'h0000_0000;
	logic         ce      = 1'b1;
	logic [3:0]   pstrb   = 4'hf;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	logic         irq;
	logic [47:0]  raise   = 48'h0000_0000_0000;
	ifsb_flags0_s req_0;
	ifsb_flags1_s req_1;
	ifsb_flags2_s req_2;
	ifsb_flags0_s flags_0;
	ifsb_flags1_s flags_1;
	ifsb_flags2_s flags_2;
	logic [31:0]  rd;
	logic         err;
	logic [31:0]  exp_w;
	logic [31:0]  got_w;
	int           n_fail      = 0;
	int           checks_done = 0;

	always #12.5 clk_sys = ~clk_sys;

	ifsb_src_model i_src (
		.raise (raise),
		.req_0 (req_0),
		.req_1 (req_1),
		.req_2 (req_2)
	);

	ifsb_top i_dut (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.ce      (ce),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.pstrb   (pstrb),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.req_0   (req_0),
		.req_1   (req_1),
		.req_2   (req_2),
		.flags_0 (flags_0),
		.flags_1 (flags_1),
		.flags_2 (flags_2),
		.irq     (irq)
	);

	task automatic complete_run();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [31:0] a,
			input logic [31:0] d);
		@(posedge clk_sys);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	initial begin
		#200_000;
		n_fail++;
		complete_run();
	end

	initial begin
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		for (int a = 0; a < 20; a += 4)
			rdchk(a, 32'h0000_0000);
		for (int r = 0; r < 3; r++) begin
			for (int b = 0; b < 16; b++) begin
				@(posedge clk_sys);
				raise <= 48'h0000_0000_0001 << (16 * r + b);
				@(posedge clk_sys);
				raise <= 48'h0000_0000_0000;
				exp_w = (r == 2 && b > 12) ? 32'h0 : 32'h1 << b;
				@(posedge clk_sys);
				got_w = 32'({flags_2, flags_1, flags_0} >> (16 * r));
				got_w = got_w & 32'h0000_ffff;
				chk(got_w, exp_w);
				rdchk(4 * r, exp_w);
				apb(1'b1, 4 * r, 32'h0000_0000);
				rdchk(4 * r, 32'h0000_0000);
			end
		end
		rdchk(32'h0000_000c, 32'h0000_0007);
		chk({31'b0, irq}, 32'h0000_0000);
		apb(1'b1, 32'h0000_0010, 32'h0000_0001);
		@(posedge clk_sys);
		chk({31'b0, irq}, 32'h0000_0001);
		rdchk(32'h0000_0010, 32'h0000_0001);
		apb(1'b1, 32'h0000_000c, 32'h0000_0001);
		@(posedge clk_sys);
		chk({31'b0, irq}, 32'h0000_0000);
		apb(1'b0, 32'h0000_0014, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		chk({31'b0, err}, 32'h0000_0001);
		apb(1'b1, 32'h0000_0100, 32'h0000_ffff);
		chk({31'b0, err}, 32'h0000_0001);
		chk({16'h0000, flags_0}, 32'h0000_0000);
		rdchk(32'h0000_000c, 32'h0000_000e);
		apb(1'b1, 32'h0000_0008, 32'h0000_ffff);
		rdchk(32'h0000_0008, 32'h0000_1fff);
		apb(1'b1, 32'h0000_0008, 32'h0000_1ffe);
		// a request lands on the very edge that writes the zero
		fork
			apb(1'b1, 32'h0000_0008, 32'h0000_0000);
			begin
				@(posedge clk_sys);
				@(posedge clk_sys);
				raise <= 48'h0001_0000_0000;
				@(posedge clk_sys);
				raise <= 48'h0000_0000_0000;
			end
		join
		rdchk(32'h0000_0008, 32'h0000_0001);
		// clock enable low across the setup cycle: the read waits and a
		// request strobe in the frozen cycles is not taken
		fork
			rdchk(32'h0000_0008, 32'h0000_0001);
			begin
				@(posedge clk_sys);
				ce    <= 1'b0;
				raise <= 48'h0000_0000_0002;
				repeat (3) @(posedge clk_sys);
				ce    <= 1'b1;
				raise <= 48'h0000_0000_0000;
			end
		join
		chk({16'h0000, flags_0}, 32'h0000_0000);
		pstrb <= 4'h1;
		apb(1'b1, 32'h0000_0000, 32'h0000_ffff);
		pstrb <= 4'h2;
		apb(1'b1, 32'h0000_0000, 32'h0000_0000);
		pstrb <= 4'hf;
		rdchk(32'h0000_0000, 32'h0000_00ff);
		apb(1'b1, 32'h0000_0000, 32'h0000_0000);
		rstn <= 1'b0;
		@(posedge clk_sys);
		rstn <= 1'b1;
		rdchk(32'h0000_0008, 32'h0000_0000);
		complete_run();
	end
endmodule
